//--- hdl/scc_pkg.sv
// Package with the configuration map, field layout and types of the slice carry chain.
package scc_pkg;

	// ----------------------------------------------------------------
	// Register bus geometry and offsets.
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFS_CONFIG = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;

	// ----------------------------------------------------------------
	// Configuration register field positions and reset value.
	// ----------------------------------------------------------------
	localparam int unsigned CFG_W          = 10;
	localparam int unsigned CFG_BOT_GEN_LO = 0;
	localparam int unsigned CFG_TOP_GEN_LO = 3;
	localparam int unsigned CFG_BOT_PROP   = 6;
	localparam int unsigned CFG_TOP_PROP   = 7;
	localparam int unsigned CFG_BOT_ROUTE  = 8;
	localparam int unsigned CFG_TOP_ROUTE  = 9;
	localparam logic [CFG_W-1:0] CFG_RESET = 10'h000;

	// ----------------------------------------------------------------
	// Status register field positions.
	// ----------------------------------------------------------------
	localparam int unsigned ST_BOT_CARRY = 0;
	localparam int unsigned ST_TOP_CARRY = 1;
	localparam int unsigned ST_BOT_SUM   = 2;
	localparam int unsigned ST_TOP_SUM   = 3;
	localparam int unsigned ST_BOT_REG   = 4;
	localparam int unsigned ST_TOP_REG   = 5;
	localparam int unsigned ST_W         = 6;

	// Generate source codes for either half.
	typedef enum logic [2:0] {
		GEN_INPUT_A = 3'h0,
		GEN_INPUT_B = 3'h1,
		GEN_PARTIAL = 3'h2,
		GEN_INIT    = 3'h3,
		GEN_ZERO    = 3'h4,
		GEN_ONE     = 3'h5
	} scc_gen_type;

	// Propagate select: the half's lookup output or a forced propagate.
	localparam logic PROP_LUT = 1'b0;
	localparam logic PROP_ONE = 1'b1;

	// Sum routing: sum on the combinational output or into the register.
	localparam logic ROUTE_COMB = 1'b0;
	localparam logic ROUTE_REG  = 1'b1;

	// Inputs of one slice half, as seen by the carry logic.
	typedef struct packed {
		logic lut_input_a;
		logic lut_input_b;
		logic init_input;
		logic lut_out;
	} scc_half_in_type;

endpackage : scc_pkg

//--- hdl/scc_slice_carry_chain.sv
// Carry, sum and partial-product logic of one two-bit logic slice with its configuration port.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module scc_slice_carry_chain
	import scc_pkg::*;
(
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_sys_rst,
	input  wire logic [ADDR_W-1:0]     i_addr,
	input  wire logic [DATA_W-1:0]     i_wr_data,
	input  wire logic                  i_wr_strobe,
	input  wire logic                  i_rd_strobe,
	output logic      [DATA_W-1:0]     o_rd_data,
	input  wire logic                  i_slice_carry_in,
	input  wire scc_half_in_type       i_bottom,
	input  wire scc_half_in_type       i_top,
	output logic                       o_bottom_comb,
	output logic                       o_top_comb,
	output logic                       o_bottom_reg,
	output logic                       o_top_reg,
	output logic                       o_slice_carry_out
);

	// ----------------------------------------------------------------
	// Helper functions.
	// ----------------------------------------------------------------

	// Generate source pick; an unused code yields a quiet 0.
	function automatic logic gen_pick(input logic [2:0] sel, input scc_half_in_type h, input logic pp);
		logic r;
		r = 1'b0;
		unique case (sel)
			GEN_INPUT_A: r = h.lut_input_a;
			GEN_INPUT_B: r = h.lut_input_b;
			GEN_PARTIAL: r = pp;
			GEN_INIT:    r = h.init_input;
			GEN_ZERO:    r = 1'b0;
			GEN_ONE:     r = 1'b1;
			default:     r = 1'b0;
		endcase
		return r;
	endfunction : gen_pick

	// Carry mux: propagate the incoming carry or take the generate term.
	function automatic logic carry_mux(input logic prop, input logic chain_carry_input, input logic gen);
		return prop ? chain_carry_input : gen;
	endfunction : carry_mux

	// ----------------------------------------------------------------
	// Configuration and registered state.
	// ----------------------------------------------------------------
	logic [CFG_W-1:0]  cfg_q;
	logic [CFG_W-1:0]  cfg_d;
	logic [DATA_W-1:0] rd_data_q;
	logic [DATA_W-1:0] rd_data_d;
	logic              bot_reg_q;
	logic              top_reg_q;

	// ----------------------------------------------------------------
	// Decode of the configuration fields.
	// ----------------------------------------------------------------
	wire logic [2:0] bot_gen_sel = cfg_q[CFG_BOT_GEN_LO +: 3];
	wire logic [2:0] top_gen_sel = cfg_q[CFG_TOP_GEN_LO +: 3];
	wire logic       bot_prop_cfg = cfg_q[CFG_BOT_PROP];
	wire logic       top_prop_cfg = cfg_q[CFG_TOP_PROP];
	wire logic       bot_route   = cfg_q[CFG_BOT_ROUTE];
	wire logic       top_route   = cfg_q[CFG_TOP_ROUTE];

	// ----------------------------------------------------------------
	// Carry chain datapath.
	// ----------------------------------------------------------------

	// Partial products of the two lookup inputs of each half.
	wire logic bot_pp = i_bottom.lut_input_a & i_bottom.lut_input_b;
	wire logic top_pp = i_top.lut_input_a & i_top.lut_input_b;

	// Generate terms through the configured selectors.
	wire logic bot_gen = gen_pick(bot_gen_sel, i_bottom, bot_pp);
	wire logic top_gen = gen_pick(top_gen_sel, i_top, top_pp);

	// Propagate selects; a forced 1 makes the half a pure carry pass-through.
	wire logic bot_prop = (bot_prop_cfg == PROP_ONE) ? 1'b1 : i_bottom.lut_out;
	wire logic top_prop = (top_prop_cfg == PROP_ONE) ? 1'b1 : i_top.lut_out;

	// The two carry muxes form the ripple path through the slice.
	wire logic bot_carry = carry_mux(bot_prop, i_slice_carry_in, bot_gen);
	wire logic top_carry = carry_mux(top_prop, bot_carry, top_gen);

	// Sum gates complete each bit with the carry entering that half.
	wire logic bot_sum = i_bottom.lut_out ^ i_slice_carry_in;
	wire logic top_sum = i_top.lut_out ^ bot_carry;

	// The carry path stays combinational so a chain of slices ripples in one cycle.
	assign o_slice_carry_out = top_carry;

	// Steering: the sum goes to the chosen output, the lookup output to the other.
	assign o_bottom_comb = (bot_route == ROUTE_REG) ? i_bottom.lut_out : bot_sum;
	assign o_top_comb    = (top_route == ROUTE_REG) ? i_top.lut_out : top_sum;
	wire logic bot_reg_d = (bot_route == ROUTE_REG) ? bot_sum : i_bottom.lut_out;
	wire logic top_reg_d = (top_route == ROUTE_REG) ? top_sum : i_top.lut_out;

	// Slice storage elements on the fabric clock.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
		begin
			bot_reg_q <= 1'b0;
			top_reg_q <= 1'b0;
		end
		else
		begin
			bot_reg_q <= bot_reg_d;
			top_reg_q <= top_reg_d;
		end
	end

	assign o_bottom_reg = bot_reg_q;
	assign o_top_reg    = top_reg_q;

	// ----------------------------------------------------------------
	// Register port.
	// ----------------------------------------------------------------

	// Live status; the carries are sampled only when software reads them.
	wire logic [ST_W-1:0] status = {top_reg_q, bot_reg_q, top_sum, bot_sum, top_carry, bot_carry};
	wire logic            wr_cfg = i_wr_strobe && (i_addr == OFS_CONFIG);
	wire logic            rd_cfg = i_rd_strobe && (i_addr == OFS_CONFIG);
	wire logic            rd_st  = i_rd_strobe && (i_addr == OFS_STATUS);

	// Unmapped reads and idle cycles return zero.
	assign cfg_d     = wr_cfg ? i_wr_data[CFG_W-1:0] : cfg_q;
	assign rd_data_d = rd_cfg ? {{(DATA_W-CFG_W){1'b0}}, cfg_q} :
	                   rd_st  ? {{(DATA_W-ST_W){1'b0}}, status} : '0;

	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
		begin
			cfg_q     <= CFG_RESET;
			rd_data_q <= '0;
		end
		else
		begin
			cfg_q     <= cfg_d;
			rd_data_q <= rd_data_d;
		end
	end

	assign o_rd_data = rd_data_q;

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	wire logic adder_cfg = (bot_gen_sel == GEN_INPUT_A) && (top_gen_sel == GEN_INPUT_A)
	                     && (bot_prop_cfg == PROP_LUT) && (top_prop_cfg == PROP_LUT);
	wire logic half_sums = (i_bottom.lut_out == (i_bottom.lut_input_a ^ i_bottom.lut_input_b))
	                     && (i_top.lut_out == (i_top.lut_input_a ^ i_top.lut_input_b));
	wire logic [2:0] add_ref = 3'({i_top.lut_input_a, i_bottom.lut_input_a})
	                         + 3'({i_top.lut_input_b, i_bottom.lut_input_b}) + 3'(i_slice_carry_in);

	property p_bot_mux;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		bot_carry == (bot_prop ? i_slice_carry_in : bot_gen);
	endproperty
	a_bot_mux: assert property (p_bot_mux) else $error("bottom carry mux wrong");

	property p_top_mux;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		o_slice_carry_out == (top_prop ? bot_carry : top_gen);
	endproperty
	a_top_mux: assert property (p_top_mux) else $error("top carry mux wrong");

	property p_top_gen;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(top_gen_sel == GEN_ONE) && !top_prop |-> o_slice_carry_out;
	endproperty
	a_top_gen: assert property (p_top_gen) else $error("top generate 1 lost");

	property p_force_prop;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(bot_prop_cfg == PROP_ONE) && (top_prop_cfg == PROP_ONE) |-> o_slice_carry_out == i_slice_carry_in;
	endproperty
	a_force_prop: assert property (p_force_prop) else $error("forced propagate broken");

	property p_sums;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(bot_route == ROUTE_COMB) && (top_route == ROUTE_COMB) |->
		(o_bottom_comb == (i_bottom.lut_out ^ i_slice_carry_in)) && (o_top_comb == (i_top.lut_out ^ bot_carry));
	endproperty
	a_sums: assert property (p_sums) else $error("sum gate wrong");

	sequence s_route_reg;
		(top_route == ROUTE_REG) && (bot_route == ROUTE_REG);
	endsequence

	property p_route;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		s_route_reg ##1 !$past(i_sys_rst) |-> (o_top_reg == $past(top_sum)) && (o_bottom_reg == $past(bot_sum));
	endproperty
	a_route: assert property (p_route) else $error("registered sum wrong");

	property p_pp;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(bot_gen_sel == GEN_PARTIAL) || (top_gen_sel == GEN_PARTIAL) |->
		((bot_gen_sel != GEN_PARTIAL) || (bot_gen == (i_bottom.lut_input_a & i_bottom.lut_input_b)))
		&& ((top_gen_sel != GEN_PARTIAL) || (top_gen == (i_top.lut_input_a & i_top.lut_input_b)));
	endproperty
	a_pp: assert property (p_pp) else $error("partial product wrong");

	property p_two_bits;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		adder_cfg && half_sums && (cfg_q[CFG_TOP_ROUTE] == ROUTE_COMB) && (cfg_q[CFG_BOT_ROUTE] == ROUTE_COMB)
		|-> {o_slice_carry_out, o_top_comb, o_bottom_comb} == add_ref;
	endproperty
	a_two_bits: assert property (p_two_bits) else $error("two-bit add wrong");

	sequence s_cfg_read;
		i_rd_strobe && (i_addr == OFS_CONFIG);
	endsequence

	property p_cfg_read;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		s_cfg_read ##1 !i_sys_rst |-> o_rd_data == {{(DATA_W-CFG_W){1'b0}}, $past(cfg_q)};
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong");

	// ----------------------------------------------------------------
	// Checks of single generate sources, forced propagate, steering, the register port and reset.
	// ----------------------------------------------------------------

	// A half generates only while its lookup output is 0 and its propagate is not forced.
	sequence s_bot_generates;
		(bot_prop_cfg == PROP_LUT) && !i_bottom.lut_out;
	endsequence

	sequence s_top_generates;
		(top_prop_cfg == PROP_LUT) && !i_top.lut_out;
	endsequence

	property p_bot_init;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		s_bot_generates ##0 (bot_gen_sel == GEN_INIT) |-> bot_carry == i_bottom.init_input;
	endproperty
	a_bot_init: assert property (p_bot_init) else $error("bottom init carry wrong");

	property p_top_init;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		s_top_generates ##0 (top_gen_sel == GEN_INIT) |-> o_slice_carry_out == i_top.init_input;
	endproperty
	a_top_init: assert property (p_top_init) else $error("top init carry wrong");

	property p_top_zero;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		s_top_generates ##0 (top_gen_sel == GEN_ZERO) |-> !o_slice_carry_out;
	endproperty
	a_top_zero: assert property (p_top_zero) else $error("top constant 0 carry wrong");

	property p_top_pp_carry;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		s_top_generates ##0 (top_gen_sel == GEN_PARTIAL)
		|-> o_slice_carry_out == (i_top.lut_input_a & i_top.lut_input_b);
	endproperty
	a_top_pp_carry: assert property (p_top_pp_carry) else $error("top product carry wrong");

	property p_bot_prop_one;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(bot_prop_cfg == PROP_ONE) |-> bot_carry == i_slice_carry_in;
	endproperty
	a_bot_prop_one: assert property (p_bot_prop_one) else $error("bottom forced propagate wrong");

	property p_comb_lut;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(bot_route == ROUTE_REG) |-> o_bottom_comb == i_bottom.lut_out;
	endproperty
	a_comb_lut: assert property (p_comb_lut) else $error("bottom steering wrong");

	// A stray write must never disturb the configuration, since the datapath follows it at once.
	property p_cfg_write;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_wr_strobe && (i_addr == OFS_CONFIG) |=> cfg_q == $past(i_wr_data[CFG_W-1:0]);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

	property p_cfg_hold;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		!(i_wr_strobe && (i_addr == OFS_CONFIG)) |=> $stable(cfg_q);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without a write");

	property p_rd_idle;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		!i_rd_strobe |=> o_rd_data == '0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");

	property p_status_read;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_rd_strobe && (i_addr == OFS_STATUS) |=> (o_rd_data[DATA_W-1:ST_W] == '0)
		&& (o_rd_data[ST_TOP_CARRY] == $past(o_slice_carry_out)) && (o_rd_data[ST_TOP_REG] == $past(o_top_reg));
	endproperty
	a_status_read: assert property (p_status_read) else $error("status readback wrong");

	// Reset is checked without a disable so that its own effect is seen.
	property p_reset_values;
		@(posedge i_clk_sys)
		i_sys_rst |=> !o_bottom_reg && !o_top_reg && (o_rd_data == '0) && (cfg_q == CFG_RESET);
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

endmodule : scc_slice_carry_chain

`default_nettype wire

//--- verification/scc_prev_slice_model.sv
// Behavioural model of the preceding slice that feeds the carry chain.
`timescale 1ns/10ps
`default_nettype none

module scc_prev_slice_model
(
	input  wire logic i_clk_sys,
	input  wire logic i_carry_value,
	input  wire logic i_slow,
	output logic      o_slice_carry_out
);

	// Slow mode answers one cycle late, as a long chain behind this slice would settle late.
	logic carry_q;

	always_ff @(posedge i_clk_sys)
	begin
		carry_q <= i_carry_value;
	end

	assign o_slice_carry_out = i_slow ? carry_q : i_carry_value;

endmodule : scc_prev_slice_model

`default_nettype wire

//--- verification/tb_top.sv
// Self-checking testbench of the slice carry chain with its configuration port.
`timescale 1ns/10ps
`default_nettype none

module tb_top
	import scc_pkg::*;
;

	// ----------------------------------------------------------------
	// Signals, rows and helpers.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] a;
		logic [1:0] b;
		logic       ci;
		logic [2:0] sum;
	} scc_tb_row_type;

	localparam scc_tb_row_type ROWS [6] = '{'{2'h1, 2'h3, 1'b1, 3'h5}, '{2'h0, 2'h0, 1'b0, 3'h0},
		'{2'h3, 2'h3, 1'b1, 3'h7}, '{2'h2, 2'h1, 1'b1, 3'h4}, '{2'h1, 2'h1, 1'b0, 3'h2}, '{2'h3, 2'h0, 1'b1, 3'h4}};

	logic              clk;
	logic              rst;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wr_data;
	logic              wr_strobe;
	logic              rd_strobe;
	logic [DATA_W-1:0] rd_data;
	logic              cin_value;
	logic              slow;
	logic              chain_carry_input;
	scc_half_in_type   bot;
	scc_half_in_type   top;
	logic              bot_comb;
	logic              top_comb;
	logic              bot_reg;
	logic              top_reg;
	logic              slice_carry_out;
	logic [DATA_W-1:0] d;
	int                errors;
	int                compares;

	scc_prev_slice_model i_prev (.i_clk_sys(clk), .i_carry_value(cin_value), .i_slow(slow), .o_slice_carry_out(chain_carry_input));

	scc_slice_carry_chain i_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_addr(addr), .i_wr_data(wr_data),
		.i_wr_strobe(wr_strobe), .i_rd_strobe(rd_strobe), .o_rd_data(rd_data), .i_slice_carry_in(chain_carry_input),
		.i_bottom(bot), .i_top(top), .o_bottom_comb(bot_comb), .o_top_comb(top_comb),
		.o_bottom_reg(bot_reg), .o_top_reg(top_reg), .o_slice_carry_out(slice_carry_out));

	// Clock generator; a 10 ns period gives 100 MHz.
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Expected generate value for a code and a pattern {input a, input b, init}.
	function automatic logic gen_exp(input logic [2:0] c, input logic [2:0] p);
		case (c)
			3'h0: return p[2];
			3'h1: return p[1];
			3'h2: return p[2] & p[1];
			3'h3: return p[0];
			3'h5: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : gen_exp

	task automatic chk1(input logic e, input logic g);
		compares++;
		if (g !== e)
		begin
			errors++;
			$display("wrong value at %0t: expected %h got %h", $time, e, g);
		end
	endtask : chk1

	task automatic chk32(input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			errors++;
			$display("wrong value at %0t: expected %h got %h", $time, e, g);
		end
	endtask : chk32

	// Each bus task starts on a fresh edge, so a strobe is never raised and lowered in one step.
	task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge clk);
		addr      <= a;
		wr_data   <= v;
		wr_strobe <= 1'b1;
		@(posedge clk);
		wr_strobe <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
		@(posedge clk);
		addr      <= a;
		rd_strobe <= 1'b1;
		@(posedge clk);
		rd_strobe <= 1'b0;
		#1;
		v = rd_data;
	endtask : reg_read

	task automatic set_halves(input logic [3:0] bv, input logic [3:0] tv, input logic ci);
		@(posedge clk);
		bot       <= scc_half_in_type'(bv);
		top       <= scc_half_in_type'(tv);
		cin_value <= ci;
		#1;
	endtask : set_halves

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test

	// Watchdog that cuts a hang short and counts it as a mismatch.
	initial
	begin
		for (int k = 0; k < 50000; k++)
			@(posedge clk);
		errors++;
		end_of_test();
	end

	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		{addr, wr_data, wr_strobe, rd_strobe, cin_value, slow} = '0;
		{bot, top, errors, compares} = '0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		reg_read(OFS_CONFIG, d);
		chk32(32'h0, d);
		$display("first reset done");
		// Reset configuration is add mode, so the rows run a two-bit adder.
		foreach (ROWS[i])
		begin
			set_halves({ROWS[i].a[0], ROWS[i].b[0], 1'b0, ^{ROWS[i].a[0], ROWS[i].b[0]}},
				{ROWS[i].a[1], ROWS[i].b[1], 1'b0, ^{ROWS[i].a[1], ROWS[i].b[1]}}, ROWS[i].ci);
			chk1(ROWS[i].sum[0], bot_comb);
			chk1(ROWS[i].sum[1], top_comb);
			chk1(ROWS[i].sum[2], slice_carry_out);
		end
		$display("adder rows done");
		// Every generate code of both halves, with lookup output 0 so the generate path is chosen.
		for (int h = 0; h < 2; h++)
			for (int c = 0; c < 8; c++)
			begin
				reg_write(OFS_CONFIG, (h == 0) ? (32'h80 | c) : (c << 3));
				for (int p = 0; p < 8; p++)
				begin
					set_halves((h == 0) ? {p[2:0], 1'b0} : 4'h0, (h == 1) ? {p[2:0], 1'b0} : 4'h0, 1'b0);
					chk1(gen_exp(c[2:0], p[2:0]), slice_carry_out);
				end
			end
		$display("generate codes done");
		// Forced propagate with both generates at 0, carry in from the slow partner.
		reg_write(OFS_CONFIG, 32'h0e4);
		slow <= 1'b1;
		for (int ci = 0; ci < 2; ci++)
		begin
			set_halves(4'h0, 4'h0, ci[0]);
			@(posedge clk);
			#1;
			chk1(ci[0], slice_carry_out);
		end
		slow <= 1'b0;
		$display("forced propagate done");
		// Sums routed to the registers; the combinational outputs then carry the lookup outputs.
		reg_write(OFS_CONFIG, 32'h300);
		set_halves(4'hc, 4'h0, 1'b1);
		chk1(1'b0, bot_comb);
		chk1(1'b0, top_comb);
		@(posedge clk);
		#1;
		chk1(1'b1, bot_reg);
		chk1(1'b1, top_reg);
		reg_read(OFS_STATUS, d);
		chk32(32'h3d, d);
		$display("register route done");
		// Back-to-back write and read; read data stands for one cycle only.
		@(posedge clk);
		addr      <= OFS_CONFIG;
		wr_data   <= 32'hffff_fe5a;
		wr_strobe <= 1'b1;
		@(posedge clk);
		wr_strobe <= 1'b0;
		rd_strobe <= 1'b1;
		@(posedge clk);
		rd_strobe <= 1'b0;
		#1;
		chk32(32'h25a, rd_data);
		@(posedge clk);
		#1;
		chk32(32'h0, rd_data);
		reg_write(OFS_STATUS, 32'hffff_ffff);
		reg_read(OFS_CONFIG, d);
		chk32(32'h25a, d);
		reg_read(4'h8, d);
		chk32(32'h0, d);
		$display("register port done");
		// Reset in mid-run clears the registered outputs and the configuration.
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		#1;
		chk1(1'b0, bot_reg);
		chk1(1'b0, top_reg);
		reg_read(OFS_CONFIG, d);
		chk32(32'h0, d);
		$display("second reset done");
		end_of_test();
	end

endmodule : tb_top

`default_nettype wire
